// ---- hdl/sos_seq.v ----
// operation sequencer: selects, starts and ends operations and runs the idle jog move
`timescale 1ns/1ps
`include "sos_seq_regs.vh"
module sos_seq #(
    parameter VEL_W = 24,
    parameter HALF_CYC = `SOS_TEST_HALF_CYC
) (
    input wire i_ref_clk, // system clock
    input wire i_sys_rst, // synchronous reset, active high
    input wire i_mode_plc, // port select strap, 1 = plc
    input wire i_ser_start, // serial start pulse
    input wire i_ser_end, // serial end pulse
    input wire i_ser_stop, // serial stop pulse
    input wire [3:0] i_ser_op, // serial operation code
    input wire [1:0] i_ser_jog, // serial jog command
    input wire i_plc_start, // plc start pulse
    input wire i_plc_end, // plc end pulse
    input wire i_plc_stop, // plc stop pulse
    input wire [3:0] i_plc_op, // plc operation code
    input wire [1:0] i_plc_jog, // plc jog command
    input wire [1:0] i_unit_type, // operation unit configuration
    input wire i_op_done, // selected operation engine finished
    input wire [VEL_W-1:0] i_jog_vel, // jog velocity parameter
    input wire [VEL_W-1:0] i_jog_acc, // jog acceleration step per cycle
    input wire [VEL_W-1:0] i_jog_dec, // jog deceleration step per cycle
    input wire [7:0] i_ovr_pct, // velocity override in percent
    input wire i_par_wr, // parameter write request
    input wire [11:0] i_par_num, // parameter number
    output reg o_idle, // idle status
    output reg o_busy, // an operation is running
    output reg [3:0] o_op_run, // running operation code
    output reg o_op_go, // engine run enable for o_op_run
    output reg o_test_cmd, // test square-wave position command level
    output reg o_jog_active, // jog motion in progress
    output reg o_jog_neg, // jog direction, 1 = negative
    output reg [VEL_W-1:0] o_jog_vel, // jog present velocity
    output reg o_par_wr_ok, // parameter write accepted
    output reg o_mech_lock, // mechanical setting mode entered
    output reg o_settle_en, // settling wait enabled
    output reg o_pend // operation start deferred behind jog
);

    localparam ST_IDLE = 2'h0;
    localparam ST_JOG = 2'h1;
    localparam ST_RUN = 2'h2;

    // a jog level that asks for motion in either direction
    function jog_move;
        input [1:0] jog;
        begin
            jog_move = (jog == `SOS_JOG_DIR_POS) || (jog == `SOS_JOG_DIR_NEG);
        end
    endfunction

    // ending type of an operation, with unit gating for indexing
    function [1:0] end_type;
        input [3:0] op;
        input [1:0] unit;
        begin
            case (op)
                `SOS_OP_TEST, `SOS_OP_IMMED: end_type = `SOS_END_NONSELF;
                `SOS_OP_MECH: end_type = `SOS_END_NONE;
                `SOS_OP_TUNE, `SOS_OP_HOME, `SOS_OP_PROG, `SOS_OP_SRCH,
                `SOS_OP_TABLE: end_type = `SOS_END_SELF;
                `SOS_OP_IDXA: end_type = (unit == `SOS_UNIT_IDXA) ? `SOS_END_SELF
                                                                  : `SOS_END_RSVD;
                `SOS_OP_IDXB: end_type = (unit == `SOS_UNIT_IDXB) ? `SOS_END_SELF
                                                                  : `SOS_END_RSVD;
                default: end_type = `SOS_END_RSVD;
            endcase
        end
    endfunction

    reg [1:0] st_r;
    reg [1:0] st_nxt;
    reg plc_sel_r;
    reg sel_caught_r;
    reg [3:0] pend_op_r;
    reg [1:0] run_type_r;
    reg [31:0] tst_cnt_r;
    reg [VEL_W-1:0] jog_tgt;
    reg [VEL_W+7:0] ovr_prod;
    reg [VEL_W+7:0] ovr_quot;
    reg [VEL_W-1:0] jog_vel_nxt;
    reg [3:0] nxt_op;

    // command source picked once after reset release
    wire c_start = plc_sel_r ? i_plc_start : i_ser_start;
    wire c_end = plc_sel_r ? i_plc_end : i_ser_end;
    wire c_stop = plc_sel_r ? i_plc_stop : i_ser_stop;
    wire [3:0] c_op = plc_sel_r ? i_plc_op : i_ser_op;
    wire [1:0] c_jog = plc_sel_r ? i_plc_jog : i_ser_jog;
    wire [1:0] c_type = end_type(c_op, i_unit_type);
    wire [1:0] p_type = end_type(pend_op_r, i_unit_type);
    wire jog_stopped = (o_jog_vel == {VEL_W{1'b0}});

    // override scales the jog parameter velocity continuously
    always @*
    begin
        ovr_prod = i_jog_vel * i_ovr_pct;
        ovr_quot = ovr_prod / `SOS_OVR_FULL;
        // the target is kept to the velocity width on purpose
        jog_tgt = ovr_quot[VEL_W-1:0];
    end

    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            sel_caught_r <= 1'b0;
            plc_sel_r <= 1'b0;
        end
        else if (!sel_caught_r)
        begin
            sel_caught_r <= 1'b1;
            plc_sel_r <= i_mode_plc;
        end
    end

    always @*
    begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE:
            begin
                if (sel_caught_r && c_start && c_type != `SOS_END_RSVD)
                    st_nxt = ST_RUN;
                else if (sel_caught_r && jog_move(c_jog))
                    st_nxt = ST_JOG;
            end
            ST_JOG:
            begin
                // no settling wait on the way back to idle
                if (!o_jog_active && jog_stopped)
                    st_nxt = (o_pend && p_type != `SOS_END_RSVD) ? ST_RUN
                                                                  : ST_IDLE;
            end
            ST_RUN:
            begin
                if (run_type_r == `SOS_END_SELF && i_op_done)
                    st_nxt = ST_IDLE;
                else if (run_type_r != `SOS_END_NONE && (c_end || c_stop))
                    st_nxt = ST_IDLE;
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    // operation that runs after this edge; settling and lock decide on it,
    // not on the code left over from the previous operation
    always @*
    begin
        nxt_op = o_op_run;
        if (st_r == ST_IDLE && st_nxt == ST_RUN)
            nxt_op = c_op;
        else if (st_r == ST_JOG && st_nxt == ST_RUN)
            nxt_op = pend_op_r;
    end

    // status outputs follow the next state so they stand with it
    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            st_r <= ST_IDLE;
            o_idle <= 1'b1;
            o_busy <= 1'b0;
            o_op_go <= 1'b0;
            o_settle_en <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            o_idle <= (st_nxt == ST_IDLE);
            o_busy <= (st_nxt == ST_RUN);
            // statement execution in code 7 is done by the engine under o_op_go
            o_op_go <= (st_nxt == ST_RUN);
            // jog settles nowhere; test and tuning end without a settling wait
            o_settle_en <= (st_nxt == ST_RUN) && (nxt_op != `SOS_OP_TEST) &&
                           (nxt_op != `SOS_OP_TUNE);
        end
    end

    // code and ending type of the operation being launched
    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            o_op_run <= 4'h0;
            run_type_r <= `SOS_END_RSVD;
        end
        else if (st_r == ST_IDLE && st_nxt == ST_RUN)
        begin
            o_op_run <= c_op;
            run_type_r <= c_type;
        end
        else if (st_r == ST_JOG && st_nxt == ST_RUN)
        begin
            o_op_run <= pend_op_r;
            run_type_r <= p_type;
        end
    end

    // mechanical setting mode is sticky until reset
    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            o_mech_lock <= 1'b0;
        else if (st_r != ST_RUN && st_nxt == ST_RUN && nxt_op == `SOS_OP_MECH)
            o_mech_lock <= 1'b1;
    end

    // start during jog is held until the rotor is still
    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            o_pend <= 1'b0;
            pend_op_r <= 4'h0;
        end
        else if (st_r == ST_JOG && c_start)
        begin
            o_pend <= 1'b1;
            pend_op_r <= c_op;
        end
        else if (st_r == ST_JOG && st_nxt != ST_JOG)
            o_pend <= 1'b0;
    end

    // jog level commands; a start also releases the jog so it can ramp down
    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            o_jog_active <= 1'b0;
            o_jog_neg <= 1'b0;
        end
        else if (st_r == ST_IDLE && st_nxt == ST_JOG)
        begin
            o_jog_active <= 1'b1;
            o_jog_neg <= (c_jog == `SOS_JOG_DIR_NEG);
        end
        else if (st_r == ST_JOG && (c_jog == `SOS_JOG_STOP || c_start))
            o_jog_active <= 1'b0;
    end

    // trapezoid ramp towards the override target, down to rest once released
    always @*
    begin
        jog_vel_nxt = o_jog_vel;
        if (st_r != ST_JOG)
            jog_vel_nxt = {VEL_W{1'b0}};
        else if (o_jog_active && o_jog_vel < jog_tgt)
            jog_vel_nxt = (jog_tgt - o_jog_vel > i_jog_acc) ?
                          o_jog_vel + i_jog_acc : jog_tgt;
        else if (!o_jog_active)
            jog_vel_nxt = (o_jog_vel > i_jog_dec) ?
                          o_jog_vel - i_jog_dec : {VEL_W{1'b0}};
        else if (o_jog_vel > jog_tgt)
            jog_vel_nxt = (o_jog_vel - jog_tgt > i_jog_dec) ?
                          o_jog_vel - i_jog_dec : jog_tgt;
    end

    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            o_jog_vel <= {VEL_W{1'b0}};
        else
            o_jog_vel <= jog_vel_nxt;
    end

    // test square wave, only while the test operation goes on running;
    // the last edge of a run must not leave a toggle behind
    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            tst_cnt_r <= 32'h0;
            o_test_cmd <= 1'b0;
        end
        else if (st_r == ST_RUN && st_nxt == ST_RUN && o_op_run == `SOS_OP_TEST)
        begin
            if (tst_cnt_r >= HALF_CYC - 1)
            begin
                tst_cnt_r <= 32'h0;
                o_test_cmd <= ~o_test_cmd;
            end
            else
                tst_cnt_r <= tst_cnt_r + 32'h1;
        end
        else
        begin
            tst_cnt_r <= 32'h0;
            o_test_cmd <= 1'b0;
        end
    end

    // general numbers are always writable; mechanical ones only inside mode 15
    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            o_par_wr_ok <= 1'b0;
        else if (i_par_wr && i_par_num <= {4'h0, `SOS_GEN_PAR_LAST})
            o_par_wr_ok <= 1'b1;
        else if (i_par_wr && i_par_num >= `SOS_MECH_PAR_FIRST &&
                 i_par_num <= `SOS_MECH_PAR_LAST)
            o_par_wr_ok <= (st_r == ST_RUN) && (o_op_run == `SOS_OP_MECH);
        else
            o_par_wr_ok <= 1'b0;
    end

endmodule // sos_seq

// ---- hdl/sos_seq_regs.vh ----
// operation codes, ending types, timing and parameter ranges for the sequencer
`ifndef SOS_SEQ_REGS_VH
`define SOS_SEQ_REGS_VH
`define SOS_OP_TEST 4'h0
`define SOS_OP_TUNE 4'h1
`define SOS_OP_HOME 4'h3
`define SOS_OP_PROG 4'h4
`define SOS_OP_SRCH 4'h5
`define SOS_OP_IMMED 4'h7
`define SOS_OP_IDXA 4'h8
`define SOS_OP_IDXB 4'h9
`define SOS_OP_TABLE 4'hA
`define SOS_OP_MECH 4'hF
`define SOS_END_SELF 2'h0
`define SOS_END_NONSELF 2'h1
`define SOS_END_NONE 2'h2
`define SOS_END_RSVD 2'h3
`define SOS_UNIT_IDXA 2'h1
`define SOS_UNIT_IDXB 2'h2
`define SOS_TEST_FREQ_MHZ 2500
`define SOS_CLK_HZ 50000000
`define SOS_TEST_HALF_CYC ((`SOS_CLK_HZ / 2) / `SOS_TEST_FREQ_MHZ * 1000)
`define SOS_GEN_PAR_LAST 8'hC7
`define SOS_MECH_PAR_FIRST 12'h0C8
`define SOS_MECH_PAR_LAST 12'h12B
`define SOS_OVR_FULL 8'h64
`define SOS_JOG_DIR_POS 2'h1
`define SOS_JOG_DIR_NEG 2'h2
`define SOS_JOG_STOP 2'h3
`endif

// ---- testbench/sos_seq_monitor.sv ----
// assertion checker for the operation sequencer ports
`timescale 1ns/1ps
module sos_seq_monitor (
    input wire i_ref_clk, // clock
    input wire i_sys_rst, // reset
    input wire i_mode_plc, // port strap
    input wire i_ser_start, // serial start
    input wire [3:0] i_ser_op, // serial op code
    input wire i_op_done, // engine done
    input wire i_par_wr, // parameter write
    input wire [11:0] i_par_num, // parameter number
    input wire o_idle, // idle
    input wire o_busy, // running
    input wire [3:0] o_op_run, // running code
    input wire o_test_cmd, // test wave
    input wire o_jog_active, // jog moving
    input wire o_par_wr_ok, // write accepted
    input wire o_mech_lock, // mechanical mode
    input wire o_settle_en, // settling wait
    input wire o_pend // deferred start
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    wire ser_go = o_idle && !i_mode_plc && i_ser_start;
    AST_START: assert property (ser_go && i_ser_op inside {0, 1, 3, 4, 5, 7, 10, 15}
        |=> o_busy && !o_idle && o_op_run == $past(i_ser_op)) else $error("start not taken");
    AST_RSVD: assert property (ser_go && i_ser_op inside {2, 6, 11, 12, 13, 14}
        |=> o_idle && !o_busy) else $error("reserved code started");
    AST_SELF: assert property (o_busy && o_op_run == 4'h1 && i_op_done
        |=> o_idle && !o_busy) else $error("self end missed");
    AST_NOEND: assert property (o_busy && o_op_run == 4'hF
        |=> o_busy && o_mech_lock) else $error("mechanical mode left");
    AST_TEST: assert property (o_test_cmd |-> o_busy && o_op_run == 4'h0)
        else $error("test wave outside test");
    AST_WAVE: assert property (o_busy && o_op_run == 4'h0 && $changed(o_test_cmd)
        |=> ($stable(o_test_cmd) || !o_busy) [*3]) else $error("test wave period");
    AST_JOG: assert property (o_busy |-> !o_jog_active)
        else $error("jog while running");
    AST_SETTLE: assert property (o_jog_active |-> !o_settle_en)
        else $error("settling in jog");
    AST_PAR: assert property (i_par_wr && i_par_num >= 12'h0C8 && i_par_num <= 12'h12B
        |=> o_par_wr_ok == $past(o_mech_lock)) else $error("mechanical write gate");
    AST_GEN: assert property (i_par_wr && i_par_num <= 12'h0C7 |=> o_par_wr_ok)
        else $error("general write refused");
    cover property (o_pend ##[1:300] o_busy);
    cover property ($fell(o_busy) && o_op_run == 4'h0);
    cover property (o_busy && o_op_run == 4'hF);
endmodule // sos_seq_monitor
bind sos_seq sos_seq_monitor sos_seq_monitor_inst (.*);

// ---- testbench/sos_ctrl_model.sv ----
// controller model: start, end and stop pulses on the serial port
`timescale 1ns/1ps
module sos_ctrl_model (
    input wire i_ref_clk, // clock
    output reg o_start, // start pulse
    output reg o_end, // end pulse
    output reg o_stop, // stop pulse
    output reg [3:0] o_op // op code
);
    initial {o_start, o_end, o_stop, o_op} = 7'h0;
    // cmd 1 start, 2 end, 3 stop; gap makes a slow controller
    task issue(input [1:0] cmd, input [3:0] op, input integer gap);
        begin
            repeat (gap + 1) @(negedge i_ref_clk);
            o_op = op;
            o_start = (cmd == 2'h1);
            o_end = (cmd == 2'h2);
            o_stop = (cmd == 2'h3);
            @(negedge i_ref_clk);
            {o_start, o_end, o_stop} = 3'h0;
            o_op = ~op;
        end
    endtask
endmodule // sos_ctrl_model

// ---- testbench/sos_seq_tb.sv ----
// self-checking bench for the operation sequencer
`timescale 1ns/1ps
`include "sos_seq_regs.vh"
module sos_seq_tb;
    reg i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_mode_plc = 1'b0, i_plc_start = 1'b0;
    reg i_plc_end = 1'b0, i_plc_stop = 1'b0, i_op_done = 1'b0, i_par_wr = 1'b0;
    reg [3:0] i_plc_op = 4'h1;
    reg [1:0] i_ser_jog = 2'h0, i_plc_jog = 2'h0, i_unit_type = 2'h0;
    reg [23:0] i_jog_vel = 24'h40, i_jog_acc = 24'h8, i_jog_dec = 24'h8;
    reg [7:0] i_ovr_pct = `SOS_OVR_FULL;
    reg [11:0] i_par_num = 12'h0;
    reg [16:0] lfsr = 17'h1835A;
    wire i_ser_start, i_ser_end, i_ser_stop, o_idle, o_busy, o_op_go, o_test_cmd;
    wire o_jog_active, o_jog_neg, o_par_wr_ok, o_mech_lock, o_settle_en, o_pend;
    wire [3:0] i_ser_op, o_op_run;
    wire [23:0] o_jog_vel;
    integer mismatches = 0, checks = 0, cyc = 0, k, n, ev;
    int self_q[$] = '{1, 3, 4, 5, 10, 8, 9};
    int rsvd_q[$] = '{2, 6, 11, 12, 13, 14, 8, 9};
    sos_seq #(.VEL_W(24), .HALF_CYC(4)) sos_seq_inst (.*);
    sos_ctrl_model sos_ctrl_model_inst (.i_ref_clk(i_ref_clk), .o_start(i_ser_start),
        .o_end(i_ser_end), .o_stop(i_ser_stop), .o_op(i_ser_op));
    always #10 i_ref_clk = ~i_ref_clk;
    function [16:0] rnd(input [16:0] s);
        rnd = {s[15:0], s[16] ^ s[13]};
    endfunction
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            checks = checks + 1;
            if (g !== e)
            begin
                mismatches = mismatches + 1;
                $display("mismatch %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task tick(input integer c);
        repeat (c) @(negedge i_ref_clk);
    endtask
    task par(input [11:0] num, input reg e);
        begin
            i_par_num = num;
            i_par_wr = 1'b1;
            tick(1);
            i_par_wr = 1'b0;
            chk("par_ok", e, o_par_wr_ok);
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", checks, mismatches);
            if (mismatches == 0 && checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    always @(posedge i_ref_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            conclude;
        end
    end
    initial
    begin
        tick(2);
        i_sys_rst = 1'b0;
        tick(2);
        chk("reset", 24'h20, {o_idle, o_busy, o_op_run});
        for (k = 0; k < 7; k = k + 1)
        begin
            i_unit_type = (self_q[k] == 9) ? `SOS_UNIT_IDXB : `SOS_UNIT_IDXA;
            sos_ctrl_model_inst.issue(2'h1, self_q[k], k % 3);
            chk("run", 24'h10 | self_q[k], {o_idle, o_busy, o_op_run});
            chk("settle", self_q[k] != 1, o_settle_en);
            i_op_done = 1'b1;
            tick(1);
            i_op_done = 1'b0;
            chk("done", 24'h20 | self_q[k], {o_idle, o_busy, o_op_run});
        end
        $display("test self_end done");
        i_unit_type = 2'h0;
        for (k = 0; k < 8; k = k + 1)
        begin
            sos_ctrl_model_inst.issue(2'h1, rsvd_q[k], 0);
            chk("rsvd", 24'h2, {o_idle, o_busy});
        end
        i_plc_start = 1'b1;
        tick(1);
        i_plc_start = 1'b0;
        chk("other_port", 24'h2, {o_idle, o_busy});
        for (k = 0; k < 2; k = k + 1)
        begin
            sos_ctrl_model_inst.issue(2'h1, k * 7, 0);
            tick(12);
            chk("hold", 24'h10 | (k * 7), {o_idle, o_busy, o_op_run});
            sos_ctrl_model_inst.issue(2'h2 + k[1:0], 4'h0, 0);
            chk("stopped", 24'h2, {o_idle, o_busy});
        end
        $display("test reserved_and_stop done");
        lfsr = rnd(lfsr);
        i_jog_vel = {14'h0, lfsr[9:0]} + 24'h10;
        i_ovr_pct = 8'h32 + {1'b0, lfsr[16:10]};
        i_jog_acc = 24'h8 + lfsr[2:0];
        i_jog_dec = 24'h8 + lfsr[5:3];
        i_ser_jog = `SOS_JOG_DIR_POS;
        ev = i_jog_vel * i_ovr_pct / 100;
        for (n = 0; n < 900 && o_jog_vel !== ev[23:0]; n = n + 1)
            tick(1);
        chk("jog_vel", ev, o_jog_vel);
        chk("jog_dir", 24'h2, {o_jog_active, o_jog_neg});
        i_ovr_pct = `SOS_OVR_FULL;
        for (n = 0; n < 900 && o_jog_vel !== i_jog_vel; n = n + 1)
            tick(1);
        chk("jog_full", i_jog_vel, o_jog_vel);
        i_ser_jog = 2'h0;
        sos_ctrl_model_inst.issue(2'h1, `SOS_OP_TUNE, 0);
        chk("pend", 24'h1, o_pend);
        for (n = 0; n < 900 && o_busy !== 1'b1; n = n + 1)
            tick(1);
        chk("deferred", 24'h11, {o_idle, o_busy, o_op_run});
        i_op_done = 1'b1;
        tick(1);
        i_op_done = 1'b0;
        i_ser_jog = `SOS_JOG_DIR_NEG;
        tick(4);
        chk("jog_dir", 24'h3, {o_jog_active, o_jog_neg});
        i_ser_jog = `SOS_JOG_STOP;
        for (n = 0; n < 900 && o_idle !== 1'b1; n = n + 1)
            tick(1);
        chk("jog_end", 24'h0, {o_jog_active, o_settle_en, o_jog_vel});
        i_ser_jog = 2'h0;
        $display("test jog done");
        par(lfsr[7:0] % 200, 1'b1);
        par(`SOS_MECH_PAR_FIRST, 1'b0);
        sos_ctrl_model_inst.issue(2'h1, `SOS_OP_MECH, 0);
        sos_ctrl_model_inst.issue(2'h3, 4'h0, 0);
        i_ser_jog = `SOS_JOG_DIR_POS;
        tick(3);
        chk("mech", 24'h2F, {o_idle, o_busy, o_jog_active, o_op_run});
        chk("lock", 24'h1, o_mech_lock);
        par(`SOS_MECH_PAR_LAST, 1'b1);
        $display("test mech_mode done");
        conclude;
    end
endmodule // sos_seq_tb
